/* File: logic/vgps_regs.sv */
// AXI4-Lite register bank for buffered set 0 and the subcarrier seed
`default_nettype none
module vgps_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Bank select pin: low selects set 0
  input wire logic bank_select,
  // Applied parameters
  output logic set0_active,
  output logic [9:0] mixed_sync_gain,
  output logic [9:0] luma_gain,
  output logic [10:0] blue_diff_gain,
  output logic [9:0] red_diff_gain,
  output logic [8:0] luma_rgb_offset,
  output logic [14:0] system_phase_offset,
  output logic pal_v_sign_flip,
  output logic [27:0] subcarrier_seed
);
  localparam int NREG = vgps_pkg::NREG;
  localparam logic [NREG*8-1:0] MASKS = {
    vgps_pkg::MASK_FULL, vgps_pkg::MASK_FULL, vgps_pkg::MASK_FULL,
    vgps_pkg::MASK_SEED0, vgps_pkg::MASK_FULL, vgps_pkg::MASK_FULL,
    vgps_pkg::MASK_OFF_SG_HI, vgps_pkg::MASK_FULL, vgps_pkg::MASK_GAIN_HI,
    vgps_pkg::MASK_FULL, vgps_pkg::MASK_FULL, vgps_pkg::MASK_FULL,
    vgps_pkg::MASK_FULL};

  logic awready_q;
  logic aw_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic wready_q;
  logic w_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] regs [NREG];
  logic [NREG-1:0] reg_we;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic wr_commit;
  logic [5:0] wr_slot;
  logic [5:0] rd_slot;

  // Word index from byte address; low two bits ignored
  assign wr_idx = awaddr_q[7:2];
  assign rd_idx = araddr[7:2];
  assign wr_hit = (wr_idx >= vgps_pkg::IDX_FIRST) && (wr_idx <= vgps_pkg::IDX_LAST);
  assign rd_hit = (rd_idx >= vgps_pkg::IDX_FIRST) && (rd_idx <= vgps_pkg::IDX_LAST);
  assign wr_slot = wr_idx - vgps_pkg::IDX_FIRST;
  assign rd_slot = rd_idx - vgps_pkg::IDX_FIRST;
  // A write completes once both address and data are held
  assign wr_commit = aw_held_q && w_held_q && !bvalid_q;

  // Write address channel; one write under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (bvalid_q && bready) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      wdata_q <= vgps_pkg::REG_RESET;
      wstrb0_q <= 1'b0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      wdata_q <= wdata[7:0];
      wstrb0_q <= wstrb[0];
    end else if (bvalid_q && bready) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR and store nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= vgps_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? vgps_pkg::RESP_OKAY : vgps_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored
  always_comb begin
    reg_we = '0;
    if (wr_commit && wr_hit && wstrb0_q) begin
      reg_we[wr_slot[3:0]] = 1'b1;
    end
  end

  // Storage stays put whatever the bank pin does (see RULE_14)
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    vgps_byte_reg #(
      .WMASK(MASKS[i*8 +: 8])
    ) u_reg (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(reg_we[i]),
      .wdata(wdata_q),
      .q(regs[i])
    );
  end

  // Read channel: address taken, data answered the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= vgps_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? {24'h000000, regs[rd_slot[3:0]]} : '0;
      rresp_q <= rd_hit ? vgps_pkg::RESP_OKAY : vgps_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Assembled fields of set 0 and the seed
  logic [9:0] msync_full;
  logic [9:0] luma_full;
  logic [10:0] u_full;
  logic [9:0] v_full;
  logic [8:0] off_full;
  logic [14:0] phase_full;
  logic vflip_full;
  logic [27:0] seed_full;
  localparam int S_MSYNC = 0;
  localparam int S_LUMA = 1;
  localparam int S_U = 2;
  localparam int S_V = 3;
  localparam int S_GHI = 4;
  localparam int S_OFF = 5;
  localparam int S_OSG = 6;
  localparam int S_PLO = 7;
  localparam int S_PHI = 8;
  localparam int S_SD0 = 9;
  localparam int S_SD1 = 10;
  localparam int S_SD2 = 11;
  localparam int S_SD3 = 12;

  // Scalars carry 8 fraction bits: low byte lsb weighs 1/256
  assign msync_full = {regs[S_OSG][vgps_pkg::SG_HI_MSB:vgps_pkg::SG_HI_LSB],
                       regs[S_MSYNC]}; // see RULE_02
  assign luma_full = {regs[S_GHI][vgps_pkg::LUMA_HI_MSB:vgps_pkg::LUMA_HI_LSB],
                      regs[S_LUMA]}; // see RULE_03
  assign u_full = {regs[S_GHI][vgps_pkg::U_HI_MSB:vgps_pkg::U_HI_LSB],
                   regs[S_U]}; // see RULE_04
  assign v_full = {regs[S_GHI][vgps_pkg::V_HI_MSB:vgps_pkg::V_HI_LSB],
                   regs[S_V]}; // see RULE_05
  assign off_full = {regs[S_OSG][vgps_pkg::OFF_MSB_BIT], regs[S_OFF]}; // see RULE_06
  assign phase_full = {regs[S_PHI],
                       regs[S_PLO][vgps_pkg::PHASE_LO_MSB:vgps_pkg::PHASE_LO_LSB]}; // see RULE_07
  assign vflip_full = regs[S_PLO][vgps_pkg::VFLIP_BIT]; // see RULE_08
  // Seed lsbs from the top nibble (see RULE_09), then whole bytes
  assign seed_full = {regs[S_SD3], regs[S_SD2], regs[S_SD1],
                      regs[S_SD0][vgps_pkg::SEED0_MSB:vgps_pkg::SEED0_LSB]}; // see RULE_10

  // Set 0 drives processing only while the pin is low (see RULE_01)
  // With the pin high the outputs rest at zero so nothing consumes set 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set0_active <= 1'b0;
      mixed_sync_gain <= '0;
      luma_gain <= '0;
      blue_diff_gain <= '0;
      red_diff_gain <= '0;
      luma_rgb_offset <= '0;
      system_phase_offset <= '0;
      pal_v_sign_flip <= 1'b0;
    end else if (!bank_select) begin
      set0_active <= 1'b1;
      mixed_sync_gain <= msync_full;
      luma_gain <= luma_full;
      blue_diff_gain <= u_full;
      red_diff_gain <= v_full;
      luma_rgb_offset <= off_full;
      system_phase_offset <= phase_full;
      pal_v_sign_flip <= vflip_full;
    end else begin
      set0_active <= 1'b0; // see RULE_14
      mixed_sync_gain <= '0;
      luma_gain <= '0;
      blue_diff_gain <= '0;
      red_diff_gain <= '0;
      luma_rgb_offset <= '0;
      system_phase_offset <= '0;
      pal_v_sign_flip <= 1'b0;
    end
  end

  // Seed is not part of the buffered set, so it is always applied
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subcarrier_seed <= '0;
    end else begin
      subcarrier_seed <= seed_full; // see RULE_12 RULE_13
    end
  end

  // Checks wait one full edge out of reset: the edge that releases reset
  // would otherwise start attempts that still meet reset values later
  logic live_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  // Checks on applied values, stored reserved bits and the write response
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !live_q);

  sequence pin_low_s;
    !bank_select;
  endsequence

  sequence pin_high_s;
    bank_select;
  endsequence

  sequence write_taken_s;
    wr_commit && wr_hit && wstrb0_q;
  endsequence

  bank_select_gate_a: assert property (pin_low_s |=> set0_active) // see RULE_01
    else $error("set 0 not active with bank pin low");
  msync_gain_a: assert property (pin_low_s |=> mixed_sync_gain ==
    {$past(regs[S_OSG][1:0]), $past(regs[S_MSYNC])}) // see RULE_02
    else $error("mixed sync gain wrongly assembled");
  luma_gain_a: assert property (pin_low_s |=> luma_gain ==
    {$past(regs[S_GHI][7:6]), $past(regs[S_LUMA])}) // see RULE_03
    else $error("luma gain wrongly assembled");
  blue_gain_a: assert property (pin_low_s |=> blue_diff_gain ==
    {$past(regs[S_GHI][5:3]), $past(regs[S_U])}) // see RULE_04
    else $error("blue difference gain wrongly assembled");
  red_gain_a: assert property (pin_low_s |=> red_diff_gain ==
    {$past(regs[S_GHI][1:0]), $past(regs[S_V])}) // see RULE_05
    else $error("red difference gain wrongly assembled");
  offset_msb_a: assert property (pin_low_s |=> luma_rgb_offset ==
    {$past(regs[S_OSG][2]), $past(regs[S_OFF])}) // see RULE_06
    else $error("luma offset wrongly assembled");
  phase_offset_a: assert property (pin_low_s |=> system_phase_offset ==
    {$past(regs[S_PHI]), $past(regs[S_PLO][7:1])}) // see RULE_07
    else $error("phase offset wrongly assembled");
  v_flip_a: assert property (pin_low_s ##1 pin_low_s |=>
    pal_v_sign_flip == $past(regs[S_PLO][0])) // see RULE_08
    else $error("V flip does not follow its bit");
  seed_low_a: assert property (##1 subcarrier_seed[3:0] == $past(regs[S_SD0][7:4])) // see RULE_09
    else $error("seed bits 3-0 wrong");
  seed_mid_a: assert property (##1 subcarrier_seed[11:4] == $past(regs[S_SD1])) // see RULE_10
    else $error("seed bits 11-4 wrong");
  seed_upper_a: assert property (##1 subcarrier_seed[19:12] == $past(regs[S_SD2])) // see RULE_12
    else $error("seed bits 19-12 wrong");
  seed_top_a: assert property (##1 subcarrier_seed[27:20] == $past(regs[S_SD3])) // see RULE_13
    else $error("seed bits 27-20 wrong");
  bank_hold_a: assert property (pin_high_s and !reg_we[S_LUMA] |=>
    $stable(regs[S_LUMA]) && !set0_active && luma_gain == '0) // see RULE_14
    else $error("set 0 touched or used with bank pin high");
  write_to_out_a: assert property (write_taken_s ##0 (wr_slot == 6'(S_LUMA)) ##1
    (!reg_we[S_LUMA] && !bank_select) |=> luma_gain[7:0] == $past(wdata_q, 2)) // see RULE_03
    else $error("written luma byte did not reach the output");
  reserved_zero_a: assert property (regs[S_SD0][3:0] == 4'h0 &&
    regs[S_OSG][7:3] == 5'h00 && regs[S_GHI][2] == 1'b0) // see RULE_11
    else $error("reserved bit stored as one");
  bresp_timing_a: assert property (write_taken_s |=> bvalid && bresp == vgps_pkg::RESP_OKAY)
    else $error("write response missing");

  sequence read_taken_s;
    arvalid && arready;
  endsequence

  // Bus answers and refusals, then set 0 outputs with the pin high
  read_answer_a: assert property (read_taken_s |=> rvalid && !arready)
    else $error("read answer missing");
  aw_take_a: assert property (awvalid && awready |=> !awready)
    else $error("write address ready not dropped");
  unmapped_wr_a: assert property (wr_commit && !wr_hit |=> bvalid &&
    bresp == vgps_pkg::RESP_SLVERR && $stable(regs[S_LUMA]))
    else $error("unmapped write not refused");
  bank_high_zero_a: assert property (pin_high_s |=> !set0_active && // see RULE_14
    mixed_sync_gain == '0 && blue_diff_gain == '0 && red_diff_gain == '0 &&
    luma_rgb_offset == '0 && system_phase_offset == '0 && !pal_v_sign_flip)
    else $error("set 0 used with bank pin high");
endmodule
`default_nettype wire

/* File: logic/vgps_pkg.sv */
// Constants for the video gain, phase and seed register bank
// Notes on behaviour
// RULE_01: Set 0 applies only while bank pin low
// RULE_02: Mixed-sync gain: low byte plus two bits
// RULE_03: Luma gain upper bits in gain bits 7-6
// RULE_04: Blue-diff gain upper bits in bits 5-3
// RULE_05: Red-diff gain upper bits in bits 1-0
// RULE_06: Nine-bit offset, msb in bit 2
// RULE_07: Phase offset from bits 7-1 plus high
// RULE_08: Bit 0 high flips PAL V sign
// RULE_09: Seed bits 3-0 from bits 7-4
// RULE_10: Seed bits 11-4 from second seed register
// RULE_11: Host writes zero to reserved bits
// RULE_12: Seed bits 19-12 from third seed register
// RULE_13: Seed bits 27-20 from fourth seed register
// RULE_14: Bank pin high keeps contents, unused
`default_nettype none
package vgps_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MSYNC_LO = 6'h17;
  localparam logic [5:0] IDX_LUMA_LO = 6'h18;
  localparam logic [5:0] IDX_U_LO = 6'h19;
  localparam logic [5:0] IDX_V_LO = 6'h1a;
  localparam logic [5:0] IDX_GAIN_HI = 6'h1b;
  localparam logic [5:0] IDX_OFF_LO = 6'h1c;
  localparam logic [5:0] IDX_OFF_SG_HI = 6'h1d;
  localparam logic [5:0] IDX_PHASE_LO = 6'h1e;
  localparam logic [5:0] IDX_PHASE_HI = 6'h1f;
  localparam logic [5:0] IDX_SEED0 = 6'h20;
  localparam logic [5:0] IDX_SEED1 = 6'h21;
  localparam logic [5:0] IDX_SEED2 = 6'h22;
  localparam logic [5:0] IDX_SEED3 = 6'h23;
  localparam logic [5:0] IDX_FIRST = IDX_MSYNC_LO;
  localparam logic [5:0] IDX_LAST = IDX_SEED3;
  localparam int NREG = 13;
  // Writable bit masks; reserved bits are stored and read as zero
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_GAIN_HI = 8'hfb;
  localparam logic [7:0] MASK_OFF_SG_HI = 8'h07;
  localparam logic [7:0] MASK_SEED0 = 8'hf0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int LUMA_HI_MSB = 7;
  localparam int LUMA_HI_LSB = 6;
  localparam int U_HI_MSB = 5;
  localparam int U_HI_LSB = 3;
  localparam int V_HI_MSB = 1;
  localparam int V_HI_LSB = 0;
  localparam int SG_HI_MSB = 1;
  localparam int SG_HI_LSB = 0;
  localparam int OFF_MSB_BIT = 2;
  localparam int PHASE_LO_MSB = 7;
  localparam int PHASE_LO_LSB = 1;
  localparam int VFLIP_BIT = 0;
  localparam int SEED0_MSB = 7;
  localparam int SEED0_LSB = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: logic/vgps_byte_reg.sv */
// One byte-wide control register with a writable-bit mask
`default_nettype none
module vgps_byte_reg #(
  parameter logic [7:0] WMASK = vgps_pkg::MASK_FULL
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  // Reserved positions never store a one, whatever the host sends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= vgps_pkg::REG_RESET;
    end else if (we) begin
      q <= wdata & WMASK;
    end
  end
endmodule
`default_nettype wire

/* File: tb/vgps_host.sv */
// Behavioural AXI4-Lite host that programs the register bank
`default_nettype none
module vgps_host (
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awprot, arprot, wstrb} = 26'h0000000;
    wdata = 32'h00000000;
  end
  // Writable bits of each index
  function automatic logic [7:0] wmask(input logic [5:0] idx);
    case (idx)
      vgps_pkg::IDX_GAIN_HI: return vgps_pkg::MASK_GAIN_HI;
      vgps_pkg::IDX_OFF_SG_HI: return vgps_pkg::MASK_OFF_SG_HI;
      vgps_pkg::IDX_SEED0: return vgps_pkg::MASK_SEED0;
      default: return vgps_pkg::MASK_FULL;
    endcase
  endfunction
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s,
                    input bit clean, output logic [1:0] r);
    logic aw_on;
    logic w_on;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h000000, clean ? (d & wmask(idx)) : d};
    wstrb <= s;
    bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_on && awready) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // Read; rready held until the answer is seen
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the gain, phase and seed register bank
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic bank_select = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic set0_active, pal_v_sign_flip;
  logic [9:0] mixed_sync_gain, luma_gain, red_diff_gain;
  logic [10:0] blue_diff_gain;
  logic [8:0] luma_rgb_offset;
  logic [14:0] system_phase_offset;
  logic [27:0] subcarrier_seed;
  logic [7:0] m [13];
  int err_count = 0;
  int n_tests = 0;
  // 50 MHz clock
  always #10 aclk = ~aclk;
  vgps_regs DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .bank_select(bank_select), .set0_active(set0_active),
    .mixed_sync_gain(mixed_sync_gain), .luma_gain(luma_gain), .blue_diff_gain(blue_diff_gain),
    .red_diff_gain(red_diff_gain), .luma_rgb_offset(luma_rgb_offset),
    .system_phase_offset(system_phase_offset), .pal_v_sign_flip(pal_v_sign_flip),
    .subcarrier_seed(subcarrier_seed));
  vgps_host host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Write one mapped register and update the model
  task automatic put(input int i, input logic [7:0] d, input logic [3:0] s, input bit clean);
    logic [1:0] r;
    logic [5:0] idx;
    idx = 6'(i + 32'h17);
    host.wr(idx, d, s, clean, r);
    if (s[0]) m[i] = d & host.wmask(idx);
    `CHK(r, vgps_pkg::RESP_OKAY)
  endtask
  // Read back every mapped register against the model
  task automatic chk_all();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < vgps_pkg::NREG; i++) begin
      host.rd(6'(i + 32'h17), d, r);
      `CHK(d, {24'h000000, m[i]})
      `CHK(r, vgps_pkg::RESP_OKAY)
    end
  endtask
  // Applied parameters once the pipeline has settled
  task automatic chk_out();
    logic b;
    repeat (3) @(posedge aclk);
    #1;
    b = bank_select;
    `CHK(set0_active, !b)
    `CHK(mixed_sync_gain, b ? 10'h000 : {m[6][1:0], m[0]})
    `CHK(luma_gain, b ? 10'h000 : {m[4][7:6], m[1]})
    `CHK(blue_diff_gain, b ? 11'h000 : {m[4][5:3], m[2]})
    `CHK(red_diff_gain, b ? 10'h000 : {m[4][1:0], m[3]})
    `CHK(luma_rgb_offset, b ? 9'h000 : {m[6][2], m[5]})
    `CHK(system_phase_offset, b ? 15'h0 : {m[8], m[7][7:1]})
    `CHK(pal_v_sign_flip, b ? 1'b0 : m[7][0])
    `CHK(subcarrier_seed, {m[12], m[11], m[10], m[9][7:4]})
  endtask
  // Watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #400us;
    err_count++;
    results();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 13; i++) m[i] = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(76));
    chk_all();
    chk_out();
    // Random values, alternately clean and with reserved bits set
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 13; i++) put(i, 8'($urandom), 4'h1, k[0]);
      chk_all();
      chk_out();
    end
    // Flip control both ways, all-ones upper fields
    put(7, 8'h01, 4'h1, 1'b1);
    put(4, 8'hff, 4'h1, 1'b0);
    chk_out();
    put(7, 8'hfe, 4'h1, 1'b1);
    chk_out();
    // Bank high: storage kept and writable, outputs withdrawn
    @(posedge aclk);
    bank_select <= 1'b1;
    chk_out();
    put(1, 8'($urandom), 4'h1, 1'b1);
    put(11, 8'($urandom), 4'h1, 1'b1);
    chk_out();
    chk_all();
    @(posedge aclk);
    bank_select <= 1'b0;
    chk_out();
    // Lane 0 strobe clear leaves the register alone
    put(0, ~m[0], 4'he, 1'b1);
    chk_all();
    // Unmapped indices on either side of the bank
    for (int i = 0; i < 2; i++) begin
      host.wr(i ? 6'h24 : 6'h16, 8'hff, 4'h1, 1'b0, r);
      `CHK(r, vgps_pkg::RESP_SLVERR)
      host.rd(i ? 6'h24 : 6'h16, d, r);
      `CHK(d, 32'h00000000)
      `CHK(r, vgps_pkg::RESP_SLVERR)
    end
    chk_all();
    chk_out();
    // Mid-run reset: storage and outputs return to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 13; i++) m[i] = 8'h00;
    chk_out();
    chk_all();
    results();
  end
endmodule
`undef CHK
`default_nettype wire
